// ==== logic/llpc_pixel_pll.sv ====
// Overview of operation
// - Reference is crystal times multiplier; loop divides it
// - Preload register seeds the division value
// - Per line, gains update division from phase error
// - Lock after four small-error lines
// - Large error returns to capture gains
// - Gains scale 3 x line length by powers
// - Line length register sets pixels per line and gain
// - Multiplier equals twice field plus three
// - Pixels per line twelve times code plus one
module llpc_pixel_pll
  import llpc_pkg::*;
#(
  parameter logic [13:0] LOCK_THRESH = 14'h0001
) (
  // Clock and reset; core_clk is the multiplied reference
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr_en,
  input wire logic [13:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Line reference
  input wire logic hsync_in,
  // To the analog multiplier
  output logic [7:0] mult_ratio,
  // Pixel clock and status
  output logic pixel_clock_out,
  output logic pixel_tick,
  output logic locked,
  output logic [15:0] division_value,
  output logic [13:0] phase_error
);
  typedef struct packed {
    logic [7:0] line_length_setting;
    logic [7:0] locked_gain_pair;
    logic [7:0] capture_gain_pair;
    logic [7:0] initial_period_preload;
    logic [7:0] crystal_multiplier;
    logic [7:0] rdata;
    logic [15:0] acc;
    logic [15:0] div;
    logic signed [LLPC_INTEG_W-1:0] integ;
    logic [11:0] pix_cnt;
    logic sync_prev;
    logic sync_seen;
    logic [2:0] good_lines;
    llpc_mode_e mode;
    logic pix_clk;
    logic tick;
    logic [13:0] err;
  } llpc_state_s;

  llpc_state_s cur;
  llpc_state_s nxt;
  logic signed [13:0] meas_err;
  logic [13:0] abs_err;
  logic [2:0] gain_first;
  logic [2:0] gain_second;
  logic signed [LLPC_INTEG_W-1:0] filt_integ;
  logic [15:0] filt_div;
  logic [15:0] acc_step;
  logic sync_rise;
  logic [11:0] line_pixels;

  function automatic logic signed [LLPC_INTEG_W-1:0] seed_integ(input logic [7:0] pp);
    logic [15:0] d;
    d = {8'h00, pp} - LLPC_PP_OFFSET;
    if ({8'h00, pp} < LLPC_PP_OFFSET + LLPC_DIV_STEP) begin
      d = LLPC_DIV_STEP;
    end
    seed_integ = LLPC_INTEG_W'(d) <<< LLPC_FRAC_W;
  endfunction : seed_integ

  function automatic logic [15:0] seed_div(input logic [7:0] pp);
    logic signed [LLPC_INTEG_W-1:0] s;
    s = seed_integ(pp);
    seed_div = s[LLPC_FRAC_W +: 16];
  endfunction : seed_div

  always_comb begin
    line_pixels = LLPC_PIX_PER_UNIT * ({6'h00, cur.line_length_setting[LLPC_LD_W-1:0]} + 12'h001);
    meas_err = $signed({2'b00, cur.pix_cnt}) - $signed({2'b00, line_pixels});
    abs_err = meas_err[13] ? 14'(-meas_err) : 14'(meas_err);
    sync_rise = hsync_in && !cur.sync_prev;
    if (cur.mode == LLPC_LOCKED) begin
      gain_first = cur.locked_gain_pair[LLPC_GAIN_FIRST_LSB +: 3];
      gain_second = cur.locked_gain_pair[LLPC_GAIN_SECOND_LSB +: 3];
    end else begin
      gain_first = cur.capture_gain_pair[LLPC_GAIN_FIRST_LSB +: 3];
      gain_second = cur.capture_gain_pair[LLPC_GAIN_SECOND_LSB +: 3];
    end
    acc_step = cur.acc + LLPC_DIV_STEP;
  end

  llpc_loop_filter u_filter (
    .err(meas_err),
    .line_length_code(cur.line_length_setting[LLPC_LD_W-1:0]),
    .gain_first(gain_first),
    .gain_second(gain_second),
    .integ(cur.integ),
    .next_integ(filt_integ),
    .next_div(filt_div)
  );

  always_comb begin
    nxt = cur;
    nxt.sync_prev = hsync_in;
    nxt.tick = 1'b0;
    // Fractional divider: each reference cycle is eight units of the division value
    if (acc_step >= cur.div) begin
      nxt.acc = acc_step - cur.div;
      nxt.tick = 1'b1;
      if (cur.pix_cnt != 12'hfff) begin
        nxt.pix_cnt = cur.pix_cnt + 12'h001;
      end
    end else begin
      nxt.acc = acc_step;
    end
    nxt.pix_clk = nxt.acc < {1'b0, cur.div[15:1]};
    if (sync_rise) begin
      nxt.pix_cnt = 12'h000;
      nxt.sync_seen = 1'b1;
      nxt.acc = 16'h0000;
      // First edge after reset only opens the measurement window
      if (cur.sync_seen) begin
        nxt.err = meas_err;
        nxt.integ = filt_integ;
        nxt.div = filt_div;
        if (abs_err > LOCK_THRESH) begin
          nxt.mode = LLPC_CAPTURE;
          nxt.good_lines = 3'h0;
        end else if (cur.good_lines + 3'h1 >= LLPC_LOCK_LINES) begin
          nxt.mode = LLPC_LOCKED;
          nxt.good_lines = LLPC_LOCK_LINES;
        end else begin
          nxt.good_lines = cur.good_lines + 3'h1;
        end
      end
    end
    if (reg_wr_en) begin
      case (reg_addr)
        LLPC_OFS_LINE_LENGTH: nxt.line_length_setting = reg_wdata;
        LLPC_OFS_LOCKED_GAIN: nxt.locked_gain_pair = reg_wdata;
        LLPC_OFS_CAPTURE_GAIN: nxt.capture_gain_pair = reg_wdata;
        LLPC_OFS_CRYSTAL_MULT: nxt.crystal_multiplier = reg_wdata;
        LLPC_OFS_INIT_PERIOD: begin
          // New standard: restart from the preload in capture
          nxt.initial_period_preload = reg_wdata;
          nxt.integ = seed_integ(reg_wdata);
          nxt.div = seed_div(reg_wdata);
          nxt.mode = LLPC_CAPTURE;
          nxt.good_lines = 3'h0;
        end
        default: begin
        end
      endcase
    end
    case (reg_addr)
      LLPC_OFS_LINE_LENGTH: nxt.rdata = nxt.line_length_setting;
      LLPC_OFS_LOCKED_GAIN: nxt.rdata = nxt.locked_gain_pair;
      LLPC_OFS_CAPTURE_GAIN: nxt.rdata = nxt.capture_gain_pair;
      LLPC_OFS_INIT_PERIOD: nxt.rdata = nxt.initial_period_preload;
      LLPC_OFS_CRYSTAL_MULT: nxt.rdata = nxt.crystal_multiplier;
      default: nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur.line_length_setting <= LLPC_RST_LINE_LENGTH;
      cur.locked_gain_pair <= LLPC_RST_LOCKED_GAIN;
      cur.capture_gain_pair <= LLPC_RST_CAPTURE_GAIN;
      cur.initial_period_preload <= LLPC_RST_INIT_PERIOD;
      cur.crystal_multiplier <= LLPC_RST_CRYSTAL_MULT;
      cur.rdata <= 8'h00;
      cur.acc <= 16'h0000;
      cur.div <= seed_div(LLPC_RST_INIT_PERIOD);
      cur.integ <= seed_integ(LLPC_RST_INIT_PERIOD);
      cur.pix_cnt <= 12'h000;
      cur.sync_prev <= 1'b0;
      cur.sync_seen <= 1'b0;
      cur.good_lines <= 3'h0;
      cur.mode <= LLPC_CAPTURE;
      cur.pix_clk <= 1'b0;
      cur.tick <= 1'b0;
      cur.err <= 14'h0000;
    end else begin
      cur <= nxt;
    end
  end

  // Ratio handed to the analog multiplier
  assign mult_ratio = 8'({4'h0, cur.crystal_multiplier[LLPC_FM_W-1:0]} + LLPC_MULT_OFFSET) << 1;
  assign reg_rdata = cur.rdata;
  assign pixel_clock_out = cur.pix_clk;
  assign pixel_tick = cur.tick;
  assign locked = cur.mode == LLPC_LOCKED;
  assign division_value = cur.div;
  assign phase_error = cur.err;
endmodule : llpc_pixel_pll

// ==== logic/llpc_pkg.sv ====
package llpc_pkg;
  localparam logic [13:0] LLPC_OFS_LINE_LENGTH = 14'h3ff0;
  localparam logic [13:0] LLPC_OFS_LOCKED_GAIN = 14'h3ff4;
  localparam logic [13:0] LLPC_OFS_CAPTURE_GAIN = 14'h3ff5;
  localparam logic [13:0] LLPC_OFS_INIT_PERIOD = 14'h3ff6;
  localparam logic [13:0] LLPC_OFS_CRYSTAL_MULT = 14'h3ff7;
  // Gain pair layout: first constant low, second constant in the upper nibble
  localparam int LLPC_GAIN_FIRST_LSB = 0;
  localparam int LLPC_GAIN_SECOND_LSB = 4;
  localparam int LLPC_LD_W = 6;
  localparam int LLPC_FM_W = 4;
  localparam logic [7:0] LLPC_RST_LINE_LENGTH = 8'h20;
  localparam logic [7:0] LLPC_RST_LOCKED_GAIN = 8'h10;
  localparam logic [7:0] LLPC_RST_CAPTURE_GAIN = 8'h42;
  localparam logic [7:0] LLPC_RST_INIT_PERIOD = 8'h80;
  localparam logic [7:0] LLPC_RST_CRYSTAL_MULT = 8'h0a;
  // Division value is kept in eighths of a reference cycle
  localparam logic [15:0] LLPC_DIV_STEP = 16'h0008;
  localparam logic [15:0] LLPC_PP_OFFSET = 16'h0018;
  localparam logic [7:0] LLPC_MULT_OFFSET = 8'h03;
  localparam logic [11:0] LLPC_PIX_PER_UNIT = 12'h00c;
  localparam logic [2:0] LLPC_LOCK_LINES = 3'h4;
  localparam int LLPC_FRAC_W = 19;
  localparam int LLPC_PROP_SHIFT = 8;
  localparam int LLPC_INTEG_W = 48;
  typedef enum {LLPC_CAPTURE, LLPC_LOCKED} llpc_mode_e;
endpackage : llpc_pkg

// ==== logic/llpc_loop_filter.sv ====
module llpc_loop_filter
  import llpc_pkg::*;
(
  // Measurement
  input wire logic signed [13:0] err,
  input wire logic [LLPC_LD_W-1:0] line_length_code,
  // Active gain pair
  input wire logic [2:0] gain_first,
  input wire logic [2:0] gain_second,
  // Integrator
  input wire logic signed [LLPC_INTEG_W-1:0] integ,
  output logic signed [LLPC_INTEG_W-1:0] next_integ,
  output logic [15:0] next_div
);
  logic signed [23:0] scaled;
  logic signed [LLPC_INTEG_W-1:0] wide;
  logic signed [LLPC_INTEG_W-1:0] prop;
  logic signed [LLPC_INTEG_W-1:0] sum;
  logic signed [LLPC_INTEG_W-1:0] quot;

  always_comb begin
    // Both terms share 3 x line length, shifted by each constant
    // Widen before the product so a large error times 3 x line length cannot wrap at 14 bits
    scaled = 24'(err) * 24'({2'b00, line_length_code, 2'b00} - {3'b000, line_length_code, 1'b0}
      + {4'b0000, line_length_code});
    wide = LLPC_INTEG_W'(scaled);
    prop = (wide <<< gain_first) <<< LLPC_PROP_SHIFT;
    next_integ = integ + (wide <<< gain_second);
    sum = next_integ + prop;
    quot = sum >>> LLPC_FRAC_W;
    // Never divide below one reference cycle, never wrap past the field
    if (quot < LLPC_INTEG_W'(LLPC_DIV_STEP)) begin
      next_div = LLPC_DIV_STEP;
    end else if (quot > LLPC_INTEG_W'(16'hffff)) begin
      next_div = 16'hffff;
    end else begin
      next_div = quot[15:0];
    end
  end
endmodule : llpc_loop_filter

// ==== sim/llpc_pll_monitor.sv ====
module llpc_pll_monitor
  import llpc_pkg::*;
#(
  parameter logic [13:0] LOCK_THRESH = 14'h0001
) (
  // Clock, reset, register port
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic [13:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Line loop
  input wire logic hsync_in,
  input wire logic [7:0] mult_ratio,
  input wire logic pixel_clock_out,
  input wire logic pixel_tick,
  input wire logic locked,
  input wire logic [15:0] division_value,
  input wire logic [13:0] phase_error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] fm;
  logic hit, pp, big;
  assign hit = reg_addr inside {LLPC_OFS_LINE_LENGTH,
    [LLPC_OFS_LOCKED_GAIN:LLPC_OFS_CRYSTAL_MULT]};
  assign pp = reg_wr_en && reg_addr == LLPC_OFS_INIT_PERIOD;
  assign big = (phase_error[13] ? -phase_error : phase_error) > LOCK_THRESH;
  // Shadow of the multiplier byte, the register itself is not visible here
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      fm <= LLPC_RST_CRYSTAL_MULT;
    else if (reg_wr_en && reg_addr == LLPC_OFS_CRYSTAL_MULT)
      fm <= reg_wdata;
  chk_mult_ratio:
    assert property (mult_ratio == 8'(2 * (fm[3:0] + 3))) else $error("ratio wrong");
  chk_write_read:
    assert property (reg_wr_en && hit |=> reg_rdata == $past(reg_wdata)) else $error("no write");
  chk_hole_zero:
    assert property (!hit |=> reg_rdata == 8'h00) else $error("hole not zero");
  chk_preload_seed:
    assert property (pp && !$rose(hsync_in) |=> !locked && division_value ==
      ($past(reg_wdata) > 8'h1f ? 16'($past(reg_wdata)) - 16'h0018 : 16'h0008))
    else $error("bad seed");
  chk_div_hold:
    assert property (!$rose(hsync_in) && !pp |=> $stable(division_value)) else $error("div moved");
  chk_lock_hold:
    assert property (!$rose(hsync_in) && !pp |=> locked == $past(locked)) else $error("lock moved");
  chk_lock_small:
    assert property ($rose(locked) |-> !big && !$past(big)) else $error("early lock");
  chk_unlock_big:
    assert property (big |-> !locked) else $error("locked on big error");
  chk_div_floor:
    assert property (division_value >= LLPC_DIV_STEP) else $error("div too small");
  cover property ($rose(locked));
  cover property ($fell(locked));
  cover property (pixel_tick ##1 pixel_clock_out);
endmodule : llpc_pll_monitor

// ==== sim/llpc_sync_src.sv ====
module llpc_sync_src (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Line length in core cycles
  input wire logic [11:0] line_cycles,
  // Sync out
  output logic hsync_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] cnt;
  // Shortening the length cuts the running line, as a source changing standard would
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 12'h000;
      hsync_in <= 1'b0;
    end else begin
      cnt <= cnt >= line_cycles - 12'h001 ? 12'h000 : cnt + 12'h001;
      hsync_in <= cnt < 12'h004;
    end
  end
endmodule : llpc_sync_src

// ==== sim/tb.sv ====
module tb
  import llpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0;
  logic [13:0] reg_addr = 14'h0000;
  logic [7:0] reg_wdata = 8'h00, rnd = 8'h4c, fm = LLPC_RST_CRYSTAL_MULT;
  logic [11:0] line_cycles = 12'hfff;
  logic hsync_in, pixel_clock_out, pixel_tick, locked;
  logic [7:0] reg_rdata, mult_ratio;
  logic [15:0] division_value;
  logic [13:0] phase_error;
  int n_errors = 0, n_tests = 0, n_pix = 0, n_hi = 0;
  logic [13:0] ofs [5] = '{LLPC_OFS_LINE_LENGTH, LLPC_OFS_LOCKED_GAIN, LLPC_OFS_CAPTURE_GAIN,
    LLPC_OFS_INIT_PERIOD, LLPC_OFS_CRYSTAL_MULT};
  logic [7:0] dflt [5] = '{LLPC_RST_LINE_LENGTH, LLPC_RST_LOCKED_GAIN, LLPC_RST_CAPTURE_GAIN,
    LLPC_RST_INIT_PERIOD, LLPC_RST_CRYSTAL_MULT};
  logic [7:0] pv [4] = '{8'h10, 8'h1f, 8'h20, 8'h00};
  initial forever #2.5 core_clk = ~core_clk;
  llpc_sync_src u_llpc_sync_src (.core_clk, .rst, .line_cycles, .hsync_in);
  llpc_pixel_pll #(.LOCK_THRESH(14'h0001)) u_llpc_pixel_pll (.core_clk, .rst, .reg_wr_en,
    .reg_addr, .reg_wdata, .reg_rdata, .hsync_in, .mult_ratio, .pixel_clock_out, .pixel_tick,
    .locked, .division_value, .phase_error);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [15:0] exp_seed(input logic [7:0] v);
    return v > 8'h1f ? 16'(v) - LLPC_PP_OFFSET : LLPC_DIV_STEP;
  endfunction : exp_seed
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    // One idle edge keeps back-to-back writes from re-raising the strobe in the same step
    @(posedge core_clk);
  endtask : wr
  // Data shows one edge after the address is taken, read at the following edge
  task automatic rd(input logic [13:0] a);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
  endtask : rd
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    cmp(division_value, exp_seed(LLPC_RST_INIT_PERIOD));
    cmp(16'(locked), 16'h0000);
    foreach (ofs[i]) begin
      rd(ofs[i]);
      cmp(16'(reg_rdata), 16'(dflt[i]));
    end
    for (int i = 0; i < 15; i++) begin
      rnd = lfsr(rnd);
      if (i % 5 == 4)
        fm = rnd;
      wr(ofs[i % 5], rnd);
      rd(ofs[i % 5]);
      cmp(16'(reg_rdata), 16'(rnd));
      cmp(16'(mult_ratio), 16'(2 * (fm[3:0] + 3)));
    end
    wr(14'h3ff2, rnd);
    rd(14'h3ff2);
    cmp(16'(reg_rdata), 16'h0000);
    $display("test registers done");
    pv[3] = lfsr(rnd);
    foreach (pv[i]) begin
      wr(LLPC_OFS_INIT_PERIOD, pv[i]);
      @(posedge core_clk);
      cmp(division_value, exp_seed(pv[i]));
      cmp(16'(locked), 16'h0000);
    end
    $display("test preload done");
    wr(LLPC_OFS_LINE_LENGTH, 8'h00);
    wr(LLPC_OFS_LOCKED_GAIN, 8'h10);
    wr(LLPC_OFS_CAPTURE_GAIN, 8'h42);
    wr(LLPC_OFS_INIT_PERIOD, 8'h28);
    line_cycles <= 12'h018;
    for (int i = 1; i <= 40; i++) begin
      @(posedge hsync_in);
      repeat (2) @(posedge core_clk);
      if (i < 4)
        cmp(16'(locked), 16'h0000);
      if (locked === 1'b1)
        break;
    end
    cmp(16'(locked), 16'h0001);
    repeat (24) begin
      @(posedge core_clk);
      n_pix += int'(pixel_tick);
      n_hi += int'(pixel_clock_out);
    end
    cmp(16'(n_pix), 16'd12);
    cmp(16'(n_hi), 16'd12);
    line_cycles <= 12'h03c;
    @(posedge hsync_in);
    repeat (2) @(posedge core_clk);
    cmp(16'(locked), 16'h0000);
    cmp(16'($signed(phase_error) > 14'sh0001), 16'h0001);
    $display("test loop done");
    print_verdict();
  end
endmodule : tb
bind llpc_pixel_pll llpc_pll_monitor #(.LOCK_THRESH(LOCK_THRESH)) u_llpc_pll_monitor (.core_clk,
  .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .hsync_in, .mult_ratio, .pixel_clock_out,
  .pixel_tick, .locked, .division_value, .phase_error);
